// [src/aet_pkg.sv]
// Shared types and constants of the AES3-style transmit encoder.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register port.
package aet_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_AUX = 8'h08;
  localparam logic [7:0] ADDR_BUF = 8'h40;
  localparam int unsigned BUF_WORDS = 24;
  localparam logic [4:0] BUF_WORD_LAST = 5'h17;

  // Frame geometry
  localparam int unsigned FRAMES_PER_BLOCK = 192;
  localparam logic [7:0] FRAME_LAST = 8'hBF;
  localparam logic [6:0] HALF_CELL_LAST = 7'h7F;
  localparam int unsigned AUDIO_BITS = 24;

  // Preamble half-cell patterns for a line that ended low
  localparam logic [7:0] PAT_X = 8'hE2;
  localparam logic [7:0] PAT_Y = 8'hE4;
  localparam logic [7:0] PAT_Z = 8'hE8;

  // Audio source codes
  localparam logic [1:0] SRC_PORT_A = 2'h0;
  localparam logic [1:0] SRC_PORT_B = 2'h1;
  localparam logic [1:0] SRC_RECEIVER = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] AUX_RESET = 8'h00;

  typedef struct packed {
    logic [13:0] rsvd;
    logic block_start_direction;
    logic [1:0] bypass_input_sel;
    logic logic_bypass;
    logic line_bypass;
    logic logic_output_disable;
    logic line_driver_disable;
    logic transmit_audio_mute;
    logic [1:0] status_user_source_sel;
    logic validity_source_sel;
    logic host_validity;
    logic word20;
    logic [1:0] frame_rate_divider_sel;
    logic master_clock_sel;
    logic [1:0] audio_source_sel;
  } aet_ctrl_t;

  typedef struct packed {
    logic v2;
    logic v1;
    logic [AUDIO_BITS-1:0] ch2;
    logic [AUDIO_BITS-1:0] ch1;
  } aet_audio_t;

  // Low bits first: status ch1, status ch2, user ch1, user ch2
  typedef struct packed {
    logic [FRAMES_PER_BLOCK-1:0] user2;
    logic [FRAMES_PER_BLOCK-1:0] user1;
    logic [FRAMES_PER_BLOCK-1:0] status2;
    logic [FRAMES_PER_BLOCK-1:0] status1;
  } aet_cs_user_t;

endpackage : aet_pkg

// [src/aet_bmc_encoder.sv]
// Biphase-mark line coder with preamble insertion for one subframe slot.
// Assumes step pulses once per half cell and half_idx counts 0..63.
`timescale 1ns/100ps
module aet_bmc_encoder (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Slot feed
  input wire logic step,
  input wire logic [5:0] half_idx,
  input wire logic [7:0] pattern,
  input wire logic data_bit,
  // Line
  output logic line
);

  logic pol;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line <= 1'b0;
      pol <= 1'b0;
    end
    else if (step)
    begin
      if (half_idx == 6'h00)
      begin
        // Even parity leaves a known level; the pattern is relative to it
        pol <= line;
        line <= pattern[7] ^ line;
      end
      else if (half_idx < 6'h08)
        line <= pattern[~half_idx[2:0]] ^ pol;
      else if (!half_idx[0])
        line <= ~line;
      else if (data_bit)
        line <= ~line;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_cell_edge;
    step && half_idx >= 6'h08 && !half_idx[0] |=> line != $past(line);
  endproperty
  a_cell_edge: assert property (p_cell_edge) else $error("no cell boundary toggle");

  property p_mid_cell;
    step && half_idx >= 6'h08 && half_idx[0] |=> (line != $past(line)) == $past(data_bit);
  endproperty
  a_mid_cell: assert property (p_mid_cell) else $error("mid-cell toggle wrong");

endmodule : aet_bmc_encoder

// [src/aet_block_buffer.sv]
// Encoder feed buffer for channel status and user bits of one block.
// Assumes load pulses on the first frame of each block.
`timescale 1ns/100ps
module aet_block_buffer #(
  parameter int unsigned FRAMES = aet_pkg::FRAMES_PER_BLOCK
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Loading
  input wire logic load,
  input wire logic [1:0] src_rx,
  input wire aet_pkg::aet_cs_user_t host_bits,
  input wire aet_pkg::aet_cs_user_t rx_bits,
  // Readout
  input wire logic [7:0] frame_idx,
  output logic [3:0] bits_out
);

  logic [FRAMES-1:0] feed [4];
  logic [4*FRAMES-1:0] host_flat;
  logic [4*FRAMES-1:0] rx_flat;

  if (FRAMES != aet_pkg::FRAMES_PER_BLOCK)
    $error("block length must match the frame counter");

  assign host_flat = host_bits;
  assign rx_flat = rx_bits;

  for (genvar g = 0; g < 4; g++)
  begin : g_part
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        feed[g] <= '0;
      else if (load)
        // Receiver bits captured last block go out now: one block late
        feed[g] <= src_rx[g/2] ? rx_flat[g*FRAMES +: FRAMES] : host_flat[g*FRAMES +: FRAMES];
    end
    assign bits_out[g] = feed[g][frame_idx];
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rx_load;
    load && src_rx[0] |=> feed[0] == $past(rx_flat[FRAMES-1:0]);
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("receiver status not loaded");

endmodule : aet_block_buffer

// [src/aet_transmit_encoder.sv]
// Two-channel AES3-family transmit encoder with AXI4-Lite control.
// Assumes all pin inputs are synchronous to aclk and master clocks run below 25 MHz.
//
// Operation
// - Frame holds two subframes, each fully formatted
// - Channel 1 uses X, channel 2 Y
// - First subframe of each block uses Z
// - Block is 192 frames, 24 status bytes per channel
// - Audio occupies positions 4..27, LSB first
// - Twenty-bit audio at 8..27, aux 4..7
// - Validity zero means sample usable
// - Parity makes positions 4..31 even
// - Data biphase-mark, preambles violate coding
// - Audio from port A, B, receiver; A default
// - Frame rate is master clock over 128..512
// - Status/user bits from host or receiver buffers
// - Receiver status/user bits lag audio one block
// - Validity from host bit or receiver
// - Outputs pick encoder or bypass line receiver
// - Disabled outputs held low
// - Mute zeroes audio and aux, recomputes parity
// - Block-start pin direction bit, input default
// - Block-start input forces Z next frame
// - Frame clock rises at each frame start
// - Block-start output high through frame 0, when driven
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module aet_transmit_encoder #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register port
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Master clocks, sampled as levels
  input wire logic master_clock_in,
  input wire logic recovered_master_clock,
  // Audio and receiver side data
  input wire aet_pkg::aet_audio_t port_a_audio,
  input wire aet_pkg::aet_audio_t port_b_audio,
  input wire aet_pkg::aet_audio_t receiver_audio,
  input wire aet_pkg::aet_cs_user_t receiver_capture_buffer,
  input wire logic [3:0] line_receiver_in,
  // Line outputs
  output logic line_driver_out,
  output logic logic_output_out,
  // Frame and block timing pins
  output logic frame_clock_out,
  input wire logic block_start_pin_in,
  output logic block_start_pin_out,
  output logic block_start_pin_oe
);

  if (ADDR_W < 8)
    $error("address must reach the buffer window");

  aet_pkg::aet_ctrl_t ctrl;
  logic [7:0] aux;
  aet_pkg::aet_cs_user_t host_side_buffer;
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_en;
  logic [31:0] rd_word;
  logic rd_ok;
  logic [7:0] ar_addr;

  function automatic logic is_buf(input logic [7:0] a);
    return a >= aet_pkg::ADDR_BUF && a[7:2] - aet_pkg::ADDR_BUF[7:2] <= 6'(aet_pkg::BUF_WORD_LAST);
  endfunction : is_buf

  function automatic logic is_mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && (a == aet_pkg::ADDR_CTRL || a == aet_pkg::ADDR_STATUS
      || a == aet_pkg::ADDR_AUX || is_buf(a));
  endfunction : is_mapped

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
    input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int j = 0; j < 4; j++)
      if (strb[j])
        r[8*j +: 8] = nw[8*j +: 8];
    return r;
  endfunction : merge

  assign ar_addr = s_axi_araddr[7:0];
  assign wr_en = aw_got && w_got && !s_axi_bvalid;

  // Write channels: address and data taken in either order, answer after both
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= aet_pkg::RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
        s_axi_awready <= 1'b0;
      end
      else if (!aw_got && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (!w_got && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (wr_en)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr) ? aet_pkg::RESP_OKAY : aet_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
    end
  end

  // Control registers; reserved bits stay zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= aet_pkg::CTRL_RESET;
      aux <= aet_pkg::AUX_RESET;
    end
    else if (wr_en && aw_addr == aet_pkg::ADDR_CTRL)
    begin
      ctrl <= merge(ctrl, w_data, w_strb) & 32'h0003_FFFF;
    end
    else if (wr_en && aw_addr == aet_pkg::ADDR_AUX)
      aux <= 8'(merge({24'h00_0000, aux}, w_data, w_strb));
  end

  // Host-side status and user buffer, one byte lane per strobe
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      host_side_buffer <= '0;
    else if (wr_en && is_buf(aw_addr) && aw_addr[1:0] == 2'h0)
      for (int j = 0; j < 4; j++)
        if (w_strb[j])
          host_side_buffer[8*(4*(aw_addr[7:2] - aet_pkg::ADDR_BUF[7:2]) + j) +: 8]
            <= w_data[8*j +: 8];
  end

  // Timing state declared here because status reads show it
  logic mclk_q;
  logic mclk_edge;
  logic [1:0] div_cnt;
  logic tick;
  logic tick_d;
  logic [6:0] hc;
  logic [7:0] frame_idx;
  logic frame_start;
  logic force_pending;
  logic bs_in_q;
  logic bs_rise;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok = is_mapped(ar_addr);
    if (ar_addr == aet_pkg::ADDR_CTRL)
      rd_word = ctrl;
    else if (ar_addr == aet_pkg::ADDR_STATUS)
      rd_word = {16'h0000, force_pending, hc, frame_idx};
    else if (ar_addr == aet_pkg::ADDR_AUX)
      rd_word = {24'h00_0000, aux};
    else if (rd_ok)
      rd_word = host_side_buffer[32*(ar_addr[7:2] - aet_pkg::ADDR_BUF[7:2]) +: 32];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= aet_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? aet_pkg::RESP_OKAY : aet_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // Master clock edges; a frame is 128 half cells, so each takes divider/128 edges
  assign mclk_edge = (ctrl.master_clock_sel ? recovered_master_clock : master_clock_in) && !mclk_q;
  assign frame_start = tick && hc == aet_pkg::HALF_CELL_LAST;
  assign bs_rise = block_start_pin_in && !bs_in_q && !ctrl.block_start_direction;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mclk_q <= 1'b0;
      div_cnt <= 2'h0;
      tick <= 1'b0;
      tick_d <= 1'b0;
    end
    else
    begin
      mclk_q <= ctrl.master_clock_sel ? recovered_master_clock : master_clock_in;
      tick <= mclk_edge && div_cnt == ctrl.frame_rate_divider_sel;
      tick_d <= tick;
      if (mclk_edge)
        div_cnt <= (div_cnt == ctrl.frame_rate_divider_sel) ? 2'h0 : div_cnt + 2'h1;
    end
  end

  // Half-cell and frame counters; reset lands just before a block start
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hc <= aet_pkg::HALF_CELL_LAST;
      frame_idx <= aet_pkg::FRAME_LAST;
    end
    else if (tick)
    begin
      hc <= hc + 7'h01;
      if (frame_start)
        frame_idx <= (force_pending || bs_rise || frame_idx == aet_pkg::FRAME_LAST)
          ? 8'h00 : frame_idx + 8'h01;
    end
  end

  // A rise at a frame start is used at once, otherwise it waits one frame
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      force_pending <= 1'b0;
      bs_in_q <= 1'b0;
    end
    else
    begin
      bs_in_q <= block_start_pin_in;
      if (frame_start)
        force_pending <= 1'b0;
      else if (bs_rise)
        force_pending <= 1'b1;
    end
  end

  logic [3:0] su_bits;
  logic block_load;
  assign block_load = frame_start && (force_pending || bs_rise || frame_idx == aet_pkg::FRAME_LAST);

  aet_block_buffer #(
    .FRAMES(aet_pkg::FRAMES_PER_BLOCK)
  ) u_feed (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(block_load),
    .src_rx(ctrl.status_user_source_sel),
    .host_bits(host_side_buffer),
    .rx_bits(receiver_capture_buffer),
    .frame_idx(frame_idx),
    .bits_out(su_bits)
  );

  // Subframe positions 4..31 as {P, C, U, V, audio}
  function automatic logic [27:0] build(input logic [23:0] s, input logic [3:0] a,
    input logic v, input logic u, input logic c, input logic mute, input logic w20);
    logic [23:0] d;
    d = mute ? 24'h00_0000 : (w20 ? {s[23:4], a} : s);
    return {^{c, u, v, d}, c, u, v, d};
  endfunction : build

  aet_pkg::aet_audio_t audio;
  logic v1;
  logic v2;
  logic [27:0] word1;
  logic [27:0] word2;

  always_comb
  begin
    case (ctrl.audio_source_sel)
      aet_pkg::SRC_PORT_B: audio = port_b_audio;
      aet_pkg::SRC_RECEIVER: audio = receiver_audio;
      default: audio = port_a_audio;
    endcase
  end

  // Zero marks a usable sample; receiver validity tracks frame by frame
  assign v1 = ctrl.validity_source_sel ? receiver_audio.v1 : ctrl.host_validity;
  assign v2 = ctrl.validity_source_sel ? receiver_audio.v2 : ctrl.host_validity;

  // Words latch just after frame start; data bits wait until slot 4
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      word1 <= 28'h000_0000;
      word2 <= 28'h000_0000;
    end
    else if (tick_d && hc == 7'h00)
    begin
      word1 <= build(audio.ch1, aux[3:0], v1, su_bits[2], su_bits[0],
        ctrl.transmit_audio_mute, ctrl.word20);
      word2 <= build(audio.ch2, aux[7:4], v2, su_bits[3], su_bits[1],
        ctrl.transmit_audio_mute, ctrl.word20);
    end
  end

  logic [7:0] pattern;
  logic [31:0] slot_word;
  logic enc_line;

  assign pattern = hc[6] ? aet_pkg::PAT_Y
    : (frame_idx == 8'h00 ? aet_pkg::PAT_Z : aet_pkg::PAT_X);
  assign slot_word = {(hc[6] ? word2 : word1), 4'h0};

  aet_bmc_encoder u_bmc (
    .aclk(aclk),
    .aresetn(aresetn),
    .step(tick_d),
    .half_idx(hc[5:0]),
    .pattern(pattern),
    .data_bit(slot_word[hc[5:1]]),
    .line(enc_line)
  );

  // Output selection and pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_driver_out <= 1'b0;
      logic_output_out <= 1'b0;
      frame_clock_out <= 1'b0;
      block_start_pin_out <= 1'b0;
      block_start_pin_oe <= 1'b0;
    end
    else
    begin
      line_driver_out <= !ctrl.line_driver_disable && (ctrl.line_bypass
        ? line_receiver_in[ctrl.bypass_input_sel] : enc_line);
      logic_output_out <= !ctrl.logic_output_disable && (ctrl.logic_bypass
        ? line_receiver_in[ctrl.bypass_input_sel] : enc_line);
      frame_clock_out <= !hc[6];
      block_start_pin_oe <= ctrl.block_start_direction;
      block_start_pin_out <= ctrl.block_start_direction && frame_idx == 8'h00;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_latch;
    tick_d && hc == 7'h00;
  endsequence

  property p_ch2_y;
    hc[6] |-> pattern == aet_pkg::PAT_Y;
  endproperty
  a_ch2_y: assert property (p_ch2_y) else $error("channel 2 preamble not Y");

  property p_z_first;
    s_latch ##0 (frame_idx == 8'h00) |-> pattern == aet_pkg::PAT_Z;
  endproperty
  a_z_first: assert property (p_z_first) else $error("block start lacks Z");

  property p_block_wrap;
    frame_start && frame_idx == aet_pkg::FRAME_LAST |=> frame_idx == 8'h00;
  endproperty
  a_block_wrap: assert property (p_block_wrap) else $error("block not 192 frames");

  property p_mute;
    s_latch ##0 ctrl.transmit_audio_mute |=> word1[23:0] == 24'h00_0000
      && word2[23:0] == 24'h00_0000 && !(^word1) && !(^word2);
  endproperty
  a_mute: assert property (p_mute) else $error("mute left audio or parity");

  property p_parity;
    s_latch |=> !(^word1) && !(^word2);
  endproperty
  a_parity: assert property (p_parity) else $error("odd parity in subframe");

  property p_disable;
    ctrl.line_driver_disable ##1 ctrl.line_driver_disable |-> !line_driver_out;
  endproperty
  a_disable: assert property (p_disable) else $error("disabled driver not low");

  property p_frame_clock;
    s_latch |=> $rose(frame_clock_out);
  endproperty
  a_frame_clock: assert property (p_frame_clock) else $error("frame clock late");

  property p_force;
    frame_start && (bs_rise || force_pending) |=> frame_idx == 8'h00 ##1 pattern == aet_pkg::PAT_Z;
  endproperty
  a_force: assert property (p_force) else $error("block start not forced");

  property p_bls_out;
    block_start_pin_out |-> block_start_pin_oe;
  endproperty
  a_bls_out: assert property (p_bls_out) else $error("block start driven as input");

  property p_bresp;
    wr_en |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write answer missing");

endmodule : aet_transmit_encoder

// [tb/aet_rx_model.sv]
// Line receiver model: biphase-mark decoder keeping the last subframe.
// Assumes six clock cycles per half cell, as with divider 0.
`timescale 1ns/100ps
module aet_rx_model (
  // Clock and observed line
  input wire logic aclk,
  input wire logic line,
  // Last decoded subframe
  output logic [7:0] pre,
  output logic [27:0] dat,
  output int unsigned count
);
  localparam int HC = 6;
  logic [63:0] cells = '0;
  logic prev = 1'b0;
  int run = 0;
  int fill = -1;
  int unsigned n_sf = 0;
  assign count = n_sf;
  // Only a preamble holds a run of three half cells: lock on it
  always @(posedge aclk)
  begin : decode
    int len;
    len = (run + HC / 2) / HC;
    if (line === prev)
      run++;
    else
    begin
      if (fill < 0 && len == 3)
        fill = 0;
      for (int i = 0; i < len && fill >= 0 && fill < 64; i++)
      begin
        cells[63 - fill] = prev;
        fill++;
      end
      if (fill == 64)
      begin
        pre <= cells[63:56] ^ {8{~cells[63]}};
        for (int k = 0; k < 28; k++)
          dat[k] <= cells[55 - 2 * k] ^ cells[54 - 2 * k];
        n_sf <= n_sf + 1;
        fill = -1;
      end
      run = 1;
      prev = line;
    end
  end
endmodule : aet_rx_model

// [tb/tb_top.sv]
// Self-checking bench for the encoder: register port, line format and pins.
// Assumes the receiver model decodes the line driver output.
`timescale 1ns/100ps
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0, line_receiver_in = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, mdiv = '0;
  logic master_clock_in = 1'b0, recovered_master_clock = 1'b0, block_start_pin_in = 1'b0;
  aet_pkg::aet_audio_t port_a_audio = '0, port_b_audio = '0, receiver_audio = '0;
  aet_pkg::aet_cs_user_t receiver_capture_buffer = '0;
  logic line_driver_out, logic_output_out, frame_clock_out;
  logic block_start_pin_out, block_start_pin_oe;
  logic [7:0] rx_pre;
  logic [27:0] rx_dat;
  int unsigned rx_count;
  int num_errors = 0, checks_done = 0;

  always #5 aclk = ~aclk;
  // Master clock at a sixth of aclk, under the sampling limit
  always @(posedge aclk)
  begin
    mdiv <= (mdiv == 2'h2) ? 2'h0 : mdiv + 2'h1;
    if (mdiv == 2'h2)
      master_clock_in <= ~master_clock_in;
  end

  aet_transmit_encoder u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .master_clock_in, .recovered_master_clock, .port_a_audio, .port_b_audio, .receiver_audio,
    .receiver_capture_buffer, .line_receiver_in, .line_driver_out, .logic_output_out,
    .frame_clock_out, .block_start_pin_in, .block_start_pin_out, .block_start_pin_oe
  );
  aet_rx_model u_rx (.aclk, .line(line_driver_out), .pre(rx_pre), .dat(rx_dat), .count(rx_count));

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'({s_axi_bvalid, s_axi_bresp}), 32'({1'b1, er}));
    @(posedge aclk);
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", 32'({s_axi_rvalid, s_axi_rresp}), 32'({1'b1, er}));
    @(posedge aclk);
  endtask : axr

  task automatic ctrl(input logic [31:0] v);
    axw(aet_pkg::ADDR_CTRL, v, aet_pkg::RESP_OKAY);
  endtask : ctrl

  task automatic sf(output logic [7:0] p, output logic [27:0] d);
    int unsigned c0;
    int n;
    c0 = rx_count;
    n = 0;
    while (rx_count == c0 && n < 3000)
    begin
      @(posedge aclk);
      n++;
    end
    chk("subframe wait", 32'(n < 3000), 32'h1);
    p = rx_pre;
    d = rx_dat;
  endtask : sf

  task automatic fc_rise(output int n);
    logic p;
    n = 0;
    do
    begin
      p = frame_clock_out;
      @(posedge aclk);
      n++;
    end
    while (!(p === 1'b0 && frame_clock_out === 1'b1) && n < 5000);
  endtask : fc_rise

  // Expected bits 4..31: audio, V, U (zero), C, then even parity
  function automatic logic [27:0] mk(input logic [23:0] a, input logic v, input logic c);
    mk = {^{c, v, a}, c, 1'b0, v, a};
  endfunction : mk

  // Skip a few subframes: audio and settings land at frame starts
  task automatic chk_frame(input logic [27:0] d1, input logic [27:0] d2);
    logic [7:0] p;
    logic [27:0] d;
    int k;
    repeat (5) sf(p, d);
    k = 0;
    do
    begin
      sf(p, d);
      k++;
    end
    while (p === aet_pkg::PAT_Y && k < 3);
    chk("pre ch1", 32'(p), 32'(aet_pkg::PAT_X));
    chk("data ch1", 32'(d), 32'(d1));
    sf(p, d);
    chk("pre ch2", 32'(p), 32'(aet_pkg::PAT_Y));
    chk("data ch2", 32'(d), 32'(d2));
  endtask : chk_frame

  task automatic t_reset();
    logic [7:0] p;
    logic [27:0] d;
    axr(aet_pkg::ADDR_CTRL, aet_pkg::CTRL_RESET, aet_pkg::RESP_OKAY);
    chk("bls oe", 32'(block_start_pin_oe), 32'h0);
    ctrl(32'h0002_0000);
    repeat (8) @(posedge aclk);
    chk("bls oe", 32'(block_start_pin_oe), 32'h1);
    chk("bls frame0", 32'(block_start_pin_out), 32'h1);
    sf(p, d);
    chk("first pre", 32'(p), 32'(aet_pkg::PAT_Z));
    sf(p, d);
    chk("second pre", 32'(p), 32'(aet_pkg::PAT_Y));
    repeat (20) @(posedge aclk);
    chk("bls frame1", 32'(block_start_pin_out), 32'h0);
    chk("logic out", 32'(logic_output_out), 32'(line_driver_out));
    ctrl(32'h0);
  endtask : t_reset

  task automatic t_audio();
    port_a_audio.ch1 <= 24'hA5_3C01;
    port_a_audio.ch2 <= 24'h5A_0FF0;
    port_b_audio.ch1 <= 24'h00_0001;
    port_b_audio.ch2 <= 24'h80_0000;
    receiver_audio <= {1'b0, 1'b1, 24'hFE_DCBA, 24'h12_3456};
    chk_frame(mk(24'hA5_3C01, 0, 0), mk(24'h5A_0FF0, 0, 0));
    ctrl(32'h0000_0040);
    chk_frame(mk(24'hA5_3C01, 1, 0), mk(24'h5A_0FF0, 1, 0));
    ctrl(32'h0000_0001);
    chk_frame(mk(24'h00_0001, 0, 0), mk(24'h80_0000, 0, 0));
    ctrl(32'h0000_0082);
    chk_frame(mk(24'h12_3456, 1, 0), mk(24'hFE_DCBA, 0, 0));
  endtask : t_audio

  task automatic t_word20();
    axw(aet_pkg::ADDR_AUX, 32'h0000_005A, aet_pkg::RESP_OKAY);
    ctrl(32'h0000_0060);
    chk_frame(mk(24'hA5_3C0A, 1, 0), mk(24'h5A_0FF5, 1, 0));
    ctrl(32'h0000_0460);
    chk_frame(mk(24'h0, 1, 0), mk(24'h0, 1, 0));
  endtask : t_word20

  task automatic t_outputs();
    ctrl(32'h0000_1800);
    repeat (8) @(posedge aclk);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      chk("outputs off", 32'({line_driver_out, logic_output_out}), 32'h0);
    end
    ctrl(32'h0001_6000);
    line_receiver_in <= 4'h4;
    repeat (8) @(posedge aclk);
    chk("bypass high", 32'({line_driver_out, logic_output_out}), 32'h3);
    line_receiver_in <= 4'hB;
    repeat (8) @(posedge aclk);
    chk("bypass low", 32'({line_driver_out, logic_output_out}), 32'h0);
    ctrl(32'h0);
  endtask : t_outputs

  task automatic t_bls_in();
    logic [7:0] p;
    logic [27:0] d;
    int n;
    axw(aet_pkg::ADDR_BUF, 32'h0000_0001, aet_pkg::RESP_OKAY);
    fc_rise(n);
    block_start_pin_in <= 1'b1;
    repeat (4) @(posedge aclk);
    block_start_pin_in <= 1'b0;
    n = 0;
    do
    begin
      sf(p, d);
      n++;
    end
    while (p !== aet_pkg::PAT_Z && n < 8);
    chk("forced pre", 32'(p), 32'(aet_pkg::PAT_Z));
    chk("forced status", 32'(d[26]), 32'h1);
  endtask : t_bls_in

  task automatic t_divider();
    int n;
    for (int d = 0; d < 4; d++)
    begin
      ctrl(32'(d) << 3);
      repeat (3) fc_rise(n);
      chk("frame period", 32'(n), 32'(768 * (d + 1)));
    end
    ctrl(32'h0);
  endtask : t_divider

  task automatic t_unmapped();
    axr(8'hF0, 32'h0, aet_pkg::RESP_SLVERR);
    axw(8'hF0, 32'h1234_5678, aet_pkg::RESP_SLVERR);
    axr(aet_pkg::ADDR_AUX, 32'h0000_005A, aet_pkg::RESP_OKAY);
    axr(aet_pkg::ADDR_CTRL, 32'h0, aet_pkg::RESP_OKAY);
  endtask : t_unmapped

  task automatic conclude();
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_audio();
    t_word20();
    t_outputs();
    t_bls_in();
    t_divider();
    t_unmapped();
    conclude();
  end

  // About twice the expected run length
  initial
  begin
    #1000000;
    num_errors++;
    conclude();
  end
endmodule : tb_top
